// ==== hdl/irq_enable_pkg.sv ====
package irq_enable_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IRQ_COUNT = 64;
  localparam int unsigned WORDS = 2;

  // byte addresses within the slave window
  localparam logic [11:0] OFFS_ENABLE_SET_LOW = 12'h000;
  localparam logic [11:0] OFFS_ENABLE_SET_HIGH = 12'h004;
  localparam logic [11:0] OFFS_ENABLED_STATUS = 12'h008;

  localparam logic [31:0] RESET_ENABLE_WORD = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } apb_req_t;

  typedef struct packed {
    logic ready;
    logic [DATA_W-1:0] rdata;
    logic slverr;
  } apb_rsp_t;

endpackage : irq_enable_pkg

// ==== hdl/interrupt_enable_set_bank.sv ====
`timescale 1ns/1ps
// What this block does
// - low register bit n is interrupt n
// - high register bit n is interrupt 32+n
// - writing one sets that interrupt's enable
// - writing zero leaves enable unchanged
// - read returns present enable state
module interrupt_enable_set_bank
  import irq_enable_pkg::*;
#(
  parameter int unsigned NUM_IRQ = IRQ_COUNT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  output logic [DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [NUM_IRQ-1:0] irq_request_i,
  output logic [NUM_IRQ-1:0] irq_enable_set_bit_o,
  output logic [NUM_IRQ-1:0] irq_gated_o
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks: refuse sizes the fixed register map cannot serve

  if (NUM_IRQ != IRQ_COUNT) begin : g_bad_count
    $error("interrupt_enable_set_bank serves exactly 64 lines");
  end

  if (NUM_IRQ != WORDS * DATA_W) begin : g_bad_split
    $error("enable lines must fill whole data words");
  end

  // the decode function knows two enable words and no more
  if (WORDS != 2) begin : g_bad_words
    $error("register map decodes exactly two enable words");
  end

  if (ADDR_W < 12) begin : g_bad_addr
    $error("address bus too narrow for the register offsets");
  end

  if (OFFS_ENABLE_SET_LOW[1:0] != 2'h0) begin : g_bad_low_align
    $error("low enable word must sit on a word boundary");
  end

  if (OFFS_ENABLE_SET_HIGH[1:0] != 2'h0) begin : g_bad_high_align
    $error("high enable word must sit on a word boundary");
  end

  if (OFFS_ENABLED_STATUS[1:0] != 2'h0) begin : g_bad_status_align
    $error("status word must sit on a word boundary");
  end

  if (OFFS_ENABLE_SET_LOW == OFFS_ENABLE_SET_HIGH) begin : g_bad_low_high
    $error("enable words must not share an offset");
  end

  if (OFFS_ENABLE_SET_LOW == OFFS_ENABLED_STATUS) begin : g_bad_low_status
    $error("low enable word must not share the status offset");
  end

  if (OFFS_ENABLE_SET_HIGH == OFFS_ENABLED_STATUS) begin : g_bad_high_status
    $error("high enable word must not share the status offset");
  end

  // reset must leave every line disabled
  if (RESET_ENABLE_WORD != '0) begin : g_bad_reset
    $error("enable words must clear to all disabled");
  end

  ////////////////////////////////////////////////////////////////////////
  // declarations

  apb_req_t req;
  apb_rsp_t next_rsp;

  logic setup_phase;
  logic access_done;
  logic write_done;
  logic read_setup;

  // driven slice by slice from the generate loops below
  wire logic [WORDS-1:0] word_hit;
  wire logic [WORDS-1:0] word_write;
  wire logic [NUM_IRQ-1:0] enable_state;
  wire logic [NUM_IRQ-1:0] next_enable_state;
  wire logic [NUM_IRQ-1:0] next_gated;

  ////////////////////////////////////////////////////////////////////////
  // address decode, shared by the write path and the read path

  function automatic logic hits_word(
    input logic [ADDR_W-1:0] addr,
    input int unsigned index
  );
    logic hit;
    hit = 1'b0;
    // an index past the map decodes to nothing
    case (index)
      0: begin
        hit = (addr == OFFS_ENABLE_SET_LOW);
      end
      1: begin
        hit = (addr == OFFS_ENABLE_SET_HIGH);
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction : hits_word

  // a zero bit in the written word keeps the stored bit as it is
  function automatic logic [DATA_W-1:0] set_ones(
    input logic [DATA_W-1:0] current,
    input logic [DATA_W-1:0] ones
  );
    logic [DATA_W-1:0] merged;
    merged = current;
    for (int unsigned b = 0; b < DATA_W; b++) begin
      if (ones[b]) begin
        merged[b] = 1'b1;
      end
    end
    return merged;
  endfunction : set_ones

  // any line enabled at all, for the summary word
  function automatic logic [DATA_W-1:0] status_word(
    input logic [NUM_IRQ-1:0] en
  );
    logic any;
    any = 1'b0;
    for (int unsigned w = 0; w < WORDS; w++) begin
      if (en[w*DATA_W +: DATA_W] != '0) begin
        any = 1'b1;
      end
    end
    return {{(DATA_W-1){1'b0}}, any};
  endfunction : status_word

  function automatic logic [DATA_W-1:0] read_word(
    input logic [ADDR_W-1:0] addr,
    input logic [NUM_IRQ-1:0] en
  );
    logic [DATA_W-1:0] data;
    data = UNMAPPED_READ;
    for (int unsigned w = 0; w < WORDS; w++) begin
      if (hits_word(addr, w)) begin
        data = en[w*DATA_W +: DATA_W];
      end
    end
    if (addr == OFFS_ENABLED_STATUS) begin
      data = status_word(en);
    end
    return data;
  endfunction : read_word

  // a request passes only while its line is enabled
  function automatic logic [DATA_W-1:0] gate_word(
    input logic [DATA_W-1:0] request,
    input logic [DATA_W-1:0] enabled
  );
    logic [DATA_W-1:0] passed;
    passed = '0;
    for (int unsigned b = 0; b < DATA_W; b++) begin
      passed[b] = request[b] && enabled[b];
    end
    return passed;
  endfunction : gate_word

  ////////////////////////////////////////////////////////////////////////
  // bus request, gathered into one carrier

  always_comb begin
    req.sel = psel_i;
    req.enable = penable_i;
    req.write = pwrite_i;
    req.addr = paddr_i;
    req.wdata = pwdata_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // transfer phases
  // no wait state: pready rises in the first access cycle, and a write
  // lands only at the edge that samples pready high, never at setup

  always_comb begin
    setup_phase = req.sel && !req.enable;
    access_done = req.sel && req.enable && pready_o;
    write_done = access_done && req.write;
    read_setup = setup_phase && !req.write;
  end

  ////////////////////////////////////////////////////////////////////////
  // enable words: ones OR in, zeros are ignored, so nothing disables here

  for (genvar w = 0; w < WORDS; w++) begin : g_word
    logic [DATA_W-1:0] word_q;
    logic [DATA_W-1:0] next_word;

    assign word_hit[w] = hits_word(req.addr, w);
    assign word_write[w] = write_done && word_hit[w];

    always_comb begin
      next_word = word_q;
      if (word_write[w]) begin
        next_word = set_ones(word_q, req.wdata);
      end
    end

    // each word keeps its own flops, so a write never disturbs the other
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        word_q <= RESET_ENABLE_WORD;
      end else begin
        word_q <= next_word;
      end
    end

    assign enable_state[w*DATA_W +: DATA_W] = word_q;
    assign next_enable_state[w*DATA_W +: DATA_W] = next_word;
  end

  ////////////////////////////////////////////////////////////////////////
  // response: read data is taken at the setup edge and stands until the
  // next read, so a late look at prdata still finds the same word

  always_comb begin
    next_rsp.ready = setup_phase;
    next_rsp.slverr = 1'b0;
    next_rsp.rdata = prdata_o;
    if (read_setup) begin
      next_rsp.rdata = read_word(req.addr, enable_state);
    end
  end

  // a single pulse; penable alone never raises it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= next_rsp.ready;
    end
  end

  // zero after reset, like an unmapped read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= UNMAPPED_READ;
    end else begin
      prdata_o <= next_rsp.rdata;
    end
  end

  // no access is ever refused: unmapped reads give zero, writes vanish
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= next_rsp.slverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enable outputs
  // registered from the next state, so they match the stored words

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_enable_set_bit_o <= '0;
    end else begin
      irq_enable_set_bit_o <= next_enable_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request gating: a disabled line never reaches the pending logic

  for (genvar w = 0; w < WORDS; w++) begin : g_gate
    logic [DATA_W-1:0] word_request;
    logic [DATA_W-1:0] word_enabled;

    assign word_request = irq_request_i[w*DATA_W +: DATA_W];
    assign word_enabled = enable_state[w*DATA_W +: DATA_W];
    assign next_gated[w*DATA_W +: DATA_W] = gate_word(word_request, word_enabled);
  end

  // one cycle behind the request, like every other output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_gated_o <= '0;
    end else begin
      irq_gated_o <= next_gated;
    end
  end

endmodule : interrupt_enable_set_bank

// ==== test/irq_enable_assertions.sv ====
`timescale 1ns/1ps
module irq_enable_assertions (
  input logic clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o,
  input logic [11:0] paddr_i,
  input logic [31:0] pwdata_i, prdata_o,
  input logic [63:0] irq_enable_set_bit_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire [63:0] e = irq_enable_set_bit_o;
  wire [63:0] n = e | {2{pwdata_i}};
  sequence wr; psel_i && penable_i && pready_o && pwrite_i; endsequence
  a_low_set: assert property (wr ##0 !paddr_i |=> e[31:0] == $past(n[31:0]))
    else $error("low");
  a_high_set: assert property (wr ##0 paddr_i == 12'h4 |=> e[63:32] == $past(n[63:32]))
    else $error("high");
  a_no_clear: assert property (!$past(rst_i) |-> (e | $past(e)) == e) else $error("clear");
  a_ready_next: assert property (psel_i && !penable_i |=> pready_o) else $error("ready");
  a_read_low: assert property (penable_i && !pwrite_i && !paddr_i |-> prdata_o == e[31:0])
    else $error("read");
  a_reset_off: assert property ($fell(rst_i) |-> e == 64'h0) else $error("reset");
endmodule : irq_enable_assertions
bind interrupt_enable_set_bank irq_enable_assertions u_chk (.*);

// ==== test/irq_source_model.sv ====
`timescale 1ns/1ps
// level requests, held until the bench changes them
module irq_source_model (
  input logic clk_i,
  input logic [63:0] src_i,
  output logic [63:0] irq_o
);
  always_ff @(posedge clk_i) irq_o <= src_i;
endmodule : irq_source_model

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o;
  logic [63:0] s = 0, irq_request_i, irq_enable_set_bit_o, irq_gated_o;
  int num_errors = 0, checked = 0;
  always #25 clk_i = ~clk_i;
  interrupt_enable_set_bank u_interrupt_enable_set_bank (.*);
  irq_source_model u_irq_source_model (.clk_i, .src_i(s), .irq_o(irq_request_i));
  task chk(input logic [63:0] g, x);
    checked++;
    num_errors += int'(g !== x);
    if (g !== x) $display("ERROR %0t %h %h", $time, g, x);
  endtask : chk
  task end_sim;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // one idle edge first, so psel never gets two assignments in one step
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i) {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge clk_i) penable_i <= 1'b1;
    do @(posedge clk_i) n++; while (pready_o !== 1'b1 && n < 8);
    {psel_i, penable_i} <= 2'h0;
    chk(n, 64'h1);
    chk(pslverr_o, 64'h0);
    if (n > 7) end_sim;
  endtask : bus
  task t_set;
    bus(1'b0, 12'h0, 32'h0);
    chk(prdata_o, 64'h0);
    bus(1'b1, 12'h0, 32'hA5A50001);
    bus(1'b1, 12'h4, 32'h80000003);
    @(posedge clk_i);
    chk(irq_enable_set_bit_o, 64'h80000003A5A50001);
    bus(1'b1, 12'h0, 32'h10);
    bus(1'b1, 12'hC, 32'hFFFFFFFF);
    bus(1'b0, 12'h0, 32'h0);
    chk(prdata_o, 64'hA5A50011);
    bus(1'b0, 12'h4, 32'h0);
    chk(prdata_o, 64'h80000003);
    bus(1'b0, 12'h8, 32'h0);
    chk(prdata_o, 64'h1);
  endtask : t_set
  task t_reset;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(irq_enable_set_bit_o, 64'h0);
    chk(irq_gated_o, 64'h0);
    bus(1'b0, 12'h4, 32'h0);
    chk(prdata_o, 64'h0);
  endtask : t_reset
  task t_gate;
    s <= 64'hFFFF0000FFFF0000;
    repeat (3) @(posedge clk_i);
    chk(irq_gated_o, 64'h80000000A5A50000);
  endtask : t_gate
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_set;
    t_gate;
    t_reset;
    end_sim;
  end
endmodule : testbench
